// ### logic/vpwtmc_core.sv
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Select low gives normal, high gives high-speed, floating gives loop-back mode.
// - Standby input low disables transmitter for low power; high enables transmission.
// - With transmission enabled, bus is active while transmit data is high.
// - Receive output is low during active bus, high otherwise.
// - Normal mode carries 10.4 kbit/s signalling with waveshaping enabled.
// - High-speed mode bypasses waveshaping for 41.6 kbit/s transfers.
// - Loop-back disables bus drive and reception, routes transmit data to receive.
// - Received bus state is filtered against short interference before output.
// - Undriven control inputs leave the device in low-power standby.
// - Standby and sleep keep the receiver alive and report bus activity.
// - After go-to-sleep, regulator enable drops once the sleep time-out elapses.
// - Bus activity or local wake reasserts the regulator enable.
// - Any edge on the local wake input is a local wake-up.
// - A high standby input always asserts the regulator enable.
// - Supply-startup reset forces standby with regulator enable asserted.
// - A supply dip during sleep tripping the reset returns to standby.
// - Over-temperature latches the transmitter passive while the receiver keeps working.
// - The thermal latch clears on the first transmit rising edge after cooling.
module vpwtmc_core #(
    parameter logic [23:0] SLEEP_TIMEOUT_CYCLES = vpwtmc_pkg::SLEEP_TIMEOUT_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] speed_loop_select_input,
    input wire logic standby_ctl_in,
    input wire logic tx_data_in,
    input wire logic bus_active_in,
    input wire logic local_wake_input,
    input wire logic over_temp_in,
    input wire logic supply_por_in,
    output logic bus_drive_out,
    output logic waveshape_en_out,
    output logic rx_data_out,
    output logic reg_enable_out
);

    vpwtmc_pkg::vpwtmc_state_s s_r;
    vpwtmc_pkg::vpwtmc_state_s s_nxt;
    logic tx_rise;
    logic lw_edge;
    logic wake;
    logic setup_rd;
    logic acc_wr;
    logic addr_hit;
    logic [vpwtmc_pkg::EVT_W-1:0] evt_set;
    logic [vpwtmc_pkg::EVT_W-1:0] evt_clr;
    logic [31:0] status_word;

    // Edge and wake terms, all taken from second or later synchroniser stages
    assign tx_rise = s_r.tx_s2 & ~s_r.tx_p;
    assign lw_edge = s_r.lw_s2 ^ s_r.lw_p;
    assign wake = s_r.bus_filt | lw_edge;

    // APB decode; the slave never stretches an access
    assign setup_rd = psel & ~penable & ~pwrite;
    assign acc_wr = psel & penable & pwrite;
    assign addr_hit = (paddr == vpwtmc_pkg::ADDR_CTRL) | (paddr == vpwtmc_pkg::ADDR_STATUS)
                    | (paddr == vpwtmc_pkg::ADDR_EVENT);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;
    assign prdata = s_r.rdata;

    // Status image shows the live mode machine state
    always_comb
    begin
        status_word = 32'h00000000;
        status_word[vpwtmc_pkg::STAT_MODE_LSB +: 3] = s_r.mode;
        status_word[vpwtmc_pkg::STAT_REGEN_BIT] = s_r.regen;
        status_word[vpwtmc_pkg::STAT_THERM_BIT] = s_r.therm;
        status_word[vpwtmc_pkg::STAT_WSHAPE_BIT] = s_r.wshape;
        status_word[vpwtmc_pkg::STAT_DRIVE_BIT] = s_r.drive;
    end

    // Whole next-state computation
    always_comb
    begin
        s_nxt = s_r;
        evt_set = '0;
        evt_clr = '0;

        // Two-flop synchronisers for every pin-level input
        s_nxt.sel_s1 = speed_loop_select_input;
        s_nxt.sel_s2 = s_r.sel_s1;
        s_nxt.sel_s3 = s_r.sel_s2; // Extra stage only to compare two settled samples
        s_nxt.stb_s1 = standby_ctl_in;
        s_nxt.stb_s2 = s_r.stb_s1;
        s_nxt.tx_s1 = tx_data_in;
        s_nxt.tx_s2 = s_r.tx_s1;
        s_nxt.tx_p = s_r.tx_s2;
        s_nxt.bus_s1 = bus_active_in;
        s_nxt.bus_s2 = s_r.bus_s1;
        s_nxt.lw_s1 = local_wake_input;
        s_nxt.lw_s2 = s_r.lw_s1;
        s_nxt.lw_p = s_r.lw_s2;
        s_nxt.ot_s1 = over_temp_in;
        s_nxt.ot_s2 = s_r.ot_s1;
        s_nxt.por_s1 = supply_por_in;
        s_nxt.por_s2 = s_r.por_s1;

        // Thermal latch: trip while hot, release only on a transmit rising edge once cool
        if (s_r.ot_s2)
        begin
            s_nxt.therm = 1'b1;
        end
        else if (s_r.therm && tx_rise)
        begin
            s_nxt.therm = 1'b0;
        end
        if (s_r.ot_s2 && !s_r.therm)
        begin
            evt_set[vpwtmc_pkg::EVT_THERM_TRIP] = 1'b1;
        end

        // Receive filter: a new bus level must persist filt_len cycles to be taken
        if (s_r.bus_s2 == s_r.bus_filt)
        begin
            s_nxt.filt_cnt = 8'h00;
        end
        else if ({1'b0, s_r.filt_cnt} + 9'h001 >= {1'b0, s_r.filt_len})
        begin
            s_nxt.bus_filt = s_r.bus_s2;
            s_nxt.filt_cnt = 8'h00;
        end
        else
        begin
            s_nxt.filt_cnt = s_r.filt_cnt + 8'h01;
        end

        // Mode machine; supply reset first, then a high standby input, then sleep handling
        if (s_r.por_s2)
        begin
            s_nxt.mode = vpwtmc_pkg::MODE_STANDBY;
            s_nxt.regen = 1'b1;
            s_nxt.slp_cnt = '0;
        end
        else if (s_r.stb_s2)
        begin
            s_nxt.regen = 1'b1;
            s_nxt.slp_cnt = '0;
            // The two select bits may settle on different edges; decode only two equal samples
            if (s_r.sel_s3 == s_r.sel_s2)
            begin
                case (s_r.sel_s2)
                    vpwtmc_pkg::SEL_LOW: s_nxt.mode = vpwtmc_pkg::MODE_NORMAL;
                    vpwtmc_pkg::SEL_HIGH: s_nxt.mode = vpwtmc_pkg::MODE_HIGH_SPEED;
                    default: s_nxt.mode = vpwtmc_pkg::MODE_LOOPBACK;
                endcase
            end
            else if ((s_r.mode == vpwtmc_pkg::MODE_SLEEP) || (s_r.mode == vpwtmc_pkg::MODE_SLEEP_WAIT))
            begin
                s_nxt.mode = vpwtmc_pkg::MODE_STANDBY; // Leave sleep now, pick the mode a cycle later
            end
        end
        else
        begin
            case (s_r.mode)
                vpwtmc_pkg::MODE_NORMAL,
                vpwtmc_pkg::MODE_HIGH_SPEED,
                vpwtmc_pkg::MODE_LOOPBACK:
                begin
                    // Falling standby input from an operating mode is the sleep command
                    s_nxt.mode = vpwtmc_pkg::MODE_SLEEP_WAIT;
                    s_nxt.slp_cnt = '0;
                end
                vpwtmc_pkg::MODE_SLEEP_WAIT:
                begin
                    if (wake)
                    begin
                        s_nxt.mode = vpwtmc_pkg::MODE_STANDBY;
                        s_nxt.regen = 1'b1;
                    end
                    else if (s_r.slp_cnt >= SLEEP_TIMEOUT_CYCLES - 24'h000001)
                    begin
                        s_nxt.mode = vpwtmc_pkg::MODE_SLEEP;
                        s_nxt.regen = 1'b0;
                    end
                    else
                    begin
                        s_nxt.slp_cnt = s_r.slp_cnt + 24'h000001;
                    end
                end
                vpwtmc_pkg::MODE_SLEEP:
                begin
                    if (wake)
                    begin
                        s_nxt.mode = vpwtmc_pkg::MODE_STANDBY;
                        s_nxt.regen = 1'b1;
                        s_nxt.slp_cnt = '0;
                    end
                end
                vpwtmc_pkg::MODE_STANDBY:
                begin
                    s_nxt.regen = 1'b1;
                end
                default:
                begin
                    s_nxt.mode = vpwtmc_pkg::MODE_STANDBY;
                    s_nxt.regen = 1'b1;
                end
            endcase
        end

        // Wake events are logged only while the regulator could be off
        if ((s_r.mode == vpwtmc_pkg::MODE_SLEEP_WAIT) || (s_r.mode == vpwtmc_pkg::MODE_SLEEP))
        begin
            evt_set[vpwtmc_pkg::EVT_BUS_WAKE] = s_r.bus_filt;
            evt_set[vpwtmc_pkg::EVT_LOCAL_WAKE] = lw_edge;
        end

        // Bus drive only in the two transmit modes and never while thermally latched
        s_nxt.drive = ((s_nxt.mode == vpwtmc_pkg::MODE_NORMAL) || (s_nxt.mode == vpwtmc_pkg::MODE_HIGH_SPEED))
                      && !s_nxt.therm && s_r.tx_s2;
        s_nxt.wshape = (s_nxt.mode == vpwtmc_pkg::MODE_NORMAL);

        // Receive output: looped transmit data, or the filtered bus in every other mode
        if (s_nxt.mode == vpwtmc_pkg::MODE_LOOPBACK)
        begin
            s_nxt.rx = ~s_r.tx_s2;
        end
        else
        begin
            s_nxt.rx = ~s_nxt.bus_filt;
        end

        // Register writes take effect at the access edge
        if (acc_wr && (paddr == vpwtmc_pkg::ADDR_CTRL))
        begin
            s_nxt.filt_len = pwdata[vpwtmc_pkg::CTRL_FILT_LSB +: vpwtmc_pkg::CTRL_FILT_W];
        end
        if (acc_wr && (paddr == vpwtmc_pkg::ADDR_EVENT))
        begin
            evt_clr = pwdata[vpwtmc_pkg::EVT_W-1:0];
        end
        // A new event in the clearing cycle survives
        s_nxt.evt = (s_r.evt & ~evt_clr) | evt_set;

        // Read data captured in the setup phase so it is stable through the access
        if (setup_rd)
        begin
            case (paddr)
                vpwtmc_pkg::ADDR_CTRL: s_nxt.rdata = {24'h000000, s_r.filt_len};
                vpwtmc_pkg::ADDR_STATUS: s_nxt.rdata = status_word;
                vpwtmc_pkg::ADDR_EVENT: s_nxt.rdata = {29'h0, s_r.evt};
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // Single state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= vpwtmc_pkg::STATE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign bus_drive_out = s_r.drive;
    assign waveshape_en_out = s_r.wshape;
    assign rx_data_out = s_r.rx;
    assign reg_enable_out = s_r.regen;

    // Checks on the mode, drive and sleep behaviour
    a_select_high_speed: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_r.por_s2 && s_r.stb_s2 && s_r.sel_s2 == vpwtmc_pkg::SEL_HIGH
         && s_r.sel_s3 == vpwtmc_pkg::SEL_HIGH)
        |=> (s_r.mode == vpwtmc_pkg::MODE_HIGH_SPEED) && !waveshape_en_out)
        else $error("High select did not give high-speed mode");

    a_standby_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.mode != vpwtmc_pkg::MODE_NORMAL && s_r.mode != vpwtmc_pkg::MODE_HIGH_SPEED)
        |-> !bus_drive_out)
        else $error("Bus driven outside a transmit mode");

    a_drive_follows_tx: assert property (@(posedge pclk) disable iff (!presetn)
        ((s_r.mode == vpwtmc_pkg::MODE_NORMAL || s_r.mode == vpwtmc_pkg::MODE_HIGH_SPEED) && !s_r.therm)
        |-> bus_drive_out == $past(s_r.tx_s2))
        else $error("Bus drive does not follow transmit data");

    a_rx_bus_state: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.mode != vpwtmc_pkg::MODE_LOOPBACK) |-> rx_data_out == !s_r.bus_filt)
        else $error("Receive output does not show filtered bus");

    a_loop_path: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.mode == vpwtmc_pkg::MODE_LOOPBACK) |-> (rx_data_out == !$past(s_r.tx_s2)) && !bus_drive_out)
        else $error("Loop-back path wrong");

    a_filter_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(s_r.bus_filt) |-> s_r.bus_filt == $past(s_r.bus_s2)
        && $past(s_r.filt_cnt) + 8'h01 >= $past(s_r.filt_len))
        else $error("Filtered bus changed without a settled input");

    a_sleep_timeout: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.mode == vpwtmc_pkg::MODE_SLEEP_WAIT && s_r.slp_cnt == SLEEP_TIMEOUT_CYCLES - 24'h000001
         && !wake && !s_r.stb_s2 && !s_r.por_s2)
        |=> !reg_enable_out && s_r.mode == vpwtmc_pkg::MODE_SLEEP)
        else $error("Regulator enable not dropped at sleep time-out");

    a_wait_keeps_regen: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.mode == vpwtmc_pkg::MODE_SLEEP_WAIT) |-> reg_enable_out)
        else $error("Regulator enable dropped before time-out");

    a_wake_regen: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.mode == vpwtmc_pkg::MODE_SLEEP && wake) |=> reg_enable_out && s_r.mode != vpwtmc_pkg::MODE_SLEEP)
        else $error("Wake-up did not restore regulator enable");

    a_stb_regen: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.stb_s2 |=> reg_enable_out)
        else $error("High standby input did not assert regulator enable");

    a_por_standby: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.por_s2 |=> s_r.mode == vpwtmc_pkg::MODE_STANDBY && reg_enable_out)
        else $error("Supply reset did not force standby");

    a_therm_passive: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.therm |-> !bus_drive_out)
        else $error("Bus driven while thermally latched");

    a_therm_release: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(s_r.therm) |-> $past(tx_rise) && !$past(s_r.ot_s2))
        else $error("Thermal latch released without a transmit rising edge");

    a_normal_shaped: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.mode == vpwtmc_pkg::MODE_NORMAL) |-> waveshape_en_out)
        else $error("Waveshaping off in normal mode");

    a_fast_unshaped: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.mode == vpwtmc_pkg::MODE_HIGH_SPEED) |-> !waveshape_en_out)
        else $error("Waveshaping on in high-speed mode");

    a_sleep_command: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_r.por_s2 && !s_r.stb_s2 && (s_r.mode == vpwtmc_pkg::MODE_NORMAL
         || s_r.mode == vpwtmc_pkg::MODE_HIGH_SPEED || s_r.mode == vpwtmc_pkg::MODE_LOOPBACK))
        |=> s_r.mode == vpwtmc_pkg::MODE_SLEEP_WAIT)
        else $error("Falling standby input did not start the sleep wait");

    a_standby_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_r.por_s2 && !s_r.stb_s2 && s_r.mode == vpwtmc_pkg::MODE_STANDBY)
        |=> s_r.mode == vpwtmc_pkg::MODE_STANDBY && reg_enable_out)
        else $error("Standby left without a driven standby input");

    a_local_wake_evt: assert property (@(posedge pclk) disable iff (!presetn)
        (lw_edge && (s_r.mode == vpwtmc_pkg::MODE_SLEEP_WAIT || s_r.mode == vpwtmc_pkg::MODE_SLEEP))
        |=> s_r.evt[vpwtmc_pkg::EVT_LOCAL_WAKE])
        else $error("Local wake edge not logged");

    a_therm_event: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.ot_s2 && !s_r.therm) |=> s_r.therm && s_r.evt[vpwtmc_pkg::EVT_THERM_TRIP])
        else $error("Thermal trip not latched and logged");

endmodule : vpwtmc_core
`default_nettype wire

// ### logic/vpwtmc_pkg.sv
`default_nettype none
package vpwtmc_pkg;

    // Register byte addresses on the APB port
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EVENT = 8'h08;

    // Control register layout
    localparam int CTRL_FILT_LSB = 0;
    localparam int CTRL_FILT_W = 8;

    // Status register layout
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_REGEN_BIT = 3;
    localparam int STAT_THERM_BIT = 4;
    localparam int STAT_WSHAPE_BIT = 5;
    localparam int STAT_DRIVE_BIT = 6;

    // Event register bits, sticky, write one to clear
    localparam int EVT_BUS_WAKE = 0;
    localparam int EVT_LOCAL_WAKE = 1;
    localparam int EVT_THERM_TRIP = 2;
    localparam int EVT_W = 3;

    // Encoded three-level select from the external detector
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_HIGH = 2'h1;
    localparam logic [1:0] SEL_FLOAT = 2'h2;

    // Timing counts in pclk cycles
    localparam int SLP_CNT_W = 24;
    localparam logic [23:0] SLEEP_TIMEOUT_DEF = 24'h0f4240;
    localparam logic [7:0] FILT_LEN_RST = 8'h64;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_HIGH_SPEED,
        MODE_LOOPBACK,
        MODE_STANDBY,
        MODE_SLEEP_WAIT,
        MODE_SLEEP
    } vpwtmc_mode_e;

    typedef struct packed {
        logic [1:0] sel_s1;
        logic [1:0] sel_s2;
        logic [1:0] sel_s3;
        logic stb_s1;
        logic stb_s2;
        logic tx_s1;
        logic tx_s2;
        logic tx_p;
        logic bus_s1;
        logic bus_s2;
        logic lw_s1;
        logic lw_s2;
        logic lw_p;
        logic ot_s1;
        logic ot_s2;
        logic por_s1;
        logic por_s2;
        vpwtmc_mode_e mode;
        logic [SLP_CNT_W-1:0] slp_cnt;
        logic [7:0] filt_cnt;
        logic [7:0] filt_len;
        logic bus_filt;
        logic therm;
        logic regen;
        logic drive;
        logic wshape;
        logic rx;
        logic [EVT_W-1:0] evt;
        logic [31:0] rdata;
    } vpwtmc_state_s;

    // Reset image: standby, regulator enabled, bus passive, receive output idle high
    localparam vpwtmc_state_s STATE_RST = '{
        sel_s1: SEL_FLOAT,
        sel_s2: SEL_FLOAT,
        sel_s3: SEL_FLOAT,
        mode: MODE_STANDBY,
        slp_cnt: 24'h000000,
        filt_cnt: 8'h00,
        filt_len: FILT_LEN_RST,
        regen: 1'b1,
        rx: 1'b1,
        evt: 3'h0,
        rdata: 32'h00000000,
        default: 1'b0
    };

endpackage : vpwtmc_pkg
`default_nettype wire

// ### bench/vpwtmc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

// Shared bus wire with its load resistor: active when any node drives it
module vpwtmc_bus_model (
    input wire logic bus_drive_out,
    input wire logic remote_drive,
    output logic bus_active_in
);
    // The load pulls the wire passive when no transmitter is active, so no stale level survives
    assign bus_active_in = bus_drive_out | remote_drive;
endmodule : vpwtmc_bus_model
`default_nettype wire

// ### bench/tb_vpw_transceiver_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_vpw_transceiver_mode_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] sel = 2'h2;
    logic standby_ctl_in = 1'b0;
    logic tx_data_in = 1'b0;
    logic local_wake_input = 1'b0;
    logic over_temp_in = 1'b0;
    logic supply_por_in = 1'b0;
    logic remote_drive = 1'b0;
    logic bus_active_in;
    logic bus_drive_out;
    logic waveshape_en_out;
    logic rx_data_out;
    logic reg_enable_out;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int checks = 0;

    // Short sleep time-out keeps the run brief
    vpwtmc_core #(.SLEEP_TIMEOUT_CYCLES(24'h000010)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .speed_loop_select_input(sel), .standby_ctl_in(standby_ctl_in), .tx_data_in(tx_data_in),
        .bus_active_in(bus_active_in), .local_wake_input(local_wake_input),
        .over_temp_in(over_temp_in), .supply_por_in(supply_por_in), .bus_drive_out(bus_drive_out),
        .waveshape_en_out(waveshape_en_out), .rx_data_out(rx_data_out), .reg_enable_out(reg_enable_out)
    );

    vpwtmc_bus_model bus_u (.bus_drive_out(bus_drive_out), .remote_drive(remote_drive), .bus_active_in(bus_active_in));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h00000000, rd, er);
        `CHK(nm, e, rd);
    endtask : rd_chk

    // Outputs are looked at on the falling edge, well clear of the updates
    task automatic settle(input int n);
        repeat (n) @(negedge pclk);
    endtask : settle

    task automatic pins(input logic e_drv, input logic e_rx, input logic e_rg);
        `CHK("bus_drive_out", e_drv, bus_drive_out);
        `CHK("rx_data_out", e_rx, rx_data_out);
        `CHK("reg_enable_out", e_rg, reg_enable_out);
    endtask : pins

    task automatic wait_regen(input logic v);
        int i;
        for (i = 0; i < 200 && reg_enable_out !== v; i++) @(negedge pclk);
        `CHK("reg_enable_out", v, reg_enable_out);
    endtask : wait_regen

    function automatic logic [31:0] st(input vpwtmc_pkg::vpwtmc_mode_e m, input logic rg, input logic th,
                                       input logic ws, input logic dr);
        st = 32'(m) | (32'(rg) << vpwtmc_pkg::STAT_REGEN_BIT) | (32'(th) << vpwtmc_pkg::STAT_THERM_BIT)
             | (32'(ws) << vpwtmc_pkg::STAT_WSHAPE_BIT) | (32'(dr) << vpwtmc_pkg::STAT_DRIVE_BIT);
    endfunction : st

    // Remote node pulse of n+1 cycles; checks the lowest receive level seen against e_rx
    task automatic pulse(input int n, input logic e_rx);
        logic seen;
        int i;
        seen = 1'b1;
        @(posedge pclk) remote_drive <= 1'b1;
        for (i = 0; i < n + 20; i++)
        begin
            @(posedge pclk);
            if (i == n) remote_drive <= 1'b0;
            @(negedge pclk);
            seen = seen & rx_data_out;
        end
        `CHK("rx_min", e_rx, seen);
    endtask : pulse

    task automatic go_sleep;
        @(posedge pclk) standby_ctl_in <= 1'b1;
        settle(8);
        @(posedge pclk) standby_ctl_in <= 1'b0;
        wait_regen(1'b0);
    endtask : go_sleep

    task automatic tally_and_finish;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // Watchdog, far beyond the few hundred cycles the tests take
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("Error watchdog expected done seen timeout");
        tally_and_finish();
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        settle(4);
        pins(1'b0, 1'b1, 1'b1);
        rd_chk(vpwtmc_pkg::ADDR_STATUS, st(vpwtmc_pkg::MODE_STANDBY, 1, 0, 0, 0), "status");
        rd_chk(vpwtmc_pkg::ADDR_CTRL, 32'(vpwtmc_pkg::FILT_LEN_RST), "ctrl");
        rd_chk(vpwtmc_pkg::ADDR_EVENT, 32'h00000000, "event");
        wr(vpwtmc_pkg::ADDR_STATUS, 32'hffffffff);
        rd_chk(vpwtmc_pkg::ADDR_STATUS, st(vpwtmc_pkg::MODE_STANDBY, 1, 0, 0, 0), "status_ro");
        apb(1'b0, 8'h0c, 32'h00000000, rd, er);
        `CHK("pslverr", 1'b1, er);
        `CHK("unmapped", 32'h00000000, rd);
        // Standby keeps the transmitter off; filter 8 rejects a short pulse
        @(posedge pclk) tx_data_in <= 1'b1;
        settle(8);
        pins(1'b0, 1'b1, 1'b1);
        @(posedge pclk) tx_data_in <= 1'b0;
        wr(vpwtmc_pkg::ADDR_CTRL, 32'h00000008);
        pulse(3, 1'b1);
        pulse(30, 1'b0);
        wr(vpwtmc_pkg::ADDR_CTRL, 32'h00000000);
        wr(vpwtmc_pkg::ADDR_EVENT, 32'h00000007);
        $display("test reset_standby done");

        // Normal, high-speed and loop-back modes from the select input
        @(posedge pclk) sel <= vpwtmc_pkg::SEL_LOW;
        standby_ctl_in <= 1'b1;
        tx_data_in <= 1'b1;
        settle(8);
        pins(1'b1, 1'b0, 1'b1);
        `CHK("waveshape", 1'b1, waveshape_en_out);
        rd_chk(vpwtmc_pkg::ADDR_STATUS, st(vpwtmc_pkg::MODE_NORMAL, 1, 0, 1, 1), "status");
        @(posedge pclk) tx_data_in <= 1'b0;
        remote_drive <= 1'b1;
        settle(8);
        pins(1'b0, 1'b0, 1'b1);
        @(posedge pclk) remote_drive <= 1'b0;
        sel <= vpwtmc_pkg::SEL_HIGH;
        tx_data_in <= 1'b1;
        settle(8);
        pins(1'b1, 1'b0, 1'b1);
        `CHK("waveshape", 1'b0, waveshape_en_out);
        rd_chk(vpwtmc_pkg::ADDR_STATUS, st(vpwtmc_pkg::MODE_HIGH_SPEED, 1, 0, 0, 1), "status");
        @(posedge pclk) sel <= vpwtmc_pkg::SEL_FLOAT;
        settle(8);
        pins(1'b0, 1'b0, 1'b1);
        rd_chk(vpwtmc_pkg::ADDR_STATUS, st(vpwtmc_pkg::MODE_LOOPBACK, 1, 0, 0, 0), "status");
        @(posedge pclk) tx_data_in <= 1'b0;
        remote_drive <= 1'b1;
        settle(8);
        pins(1'b0, 1'b1, 1'b1);
        @(posedge pclk) remote_drive <= 1'b0;
        sel <= vpwtmc_pkg::SEL_LOW;
        $display("test modes done");

        // Thermal latch holds until a transmit rising edge after cooling
        @(posedge pclk) tx_data_in <= 1'b1;
        over_temp_in <= 1'b1;
        settle(8);
        pins(1'b0, 1'b1, 1'b1);
        @(posedge pclk) over_temp_in <= 1'b0;
        settle(8);
        rd_chk(vpwtmc_pkg::ADDR_STATUS, st(vpwtmc_pkg::MODE_NORMAL, 1, 1, 1, 0), "status");
        rd_chk(vpwtmc_pkg::ADDR_EVENT, 32'h1 << vpwtmc_pkg::EVT_THERM_TRIP, "event");
        @(posedge pclk) tx_data_in <= 1'b0;
        settle(8);
        @(posedge pclk) tx_data_in <= 1'b1;
        settle(8);
        pins(1'b1, 1'b0, 1'b1);
        @(posedge pclk) tx_data_in <= 1'b0;
        wr(vpwtmc_pkg::ADDR_EVENT, 32'h00000004);
        rd_chk(vpwtmc_pkg::ADDR_EVENT, 32'h00000000, "event_clr");
        $display("test thermal done");

        // Sleep time-out, then bus, local and standby wake-ups, then supply reset
        @(posedge pclk) standby_ctl_in <= 1'b0;
        settle(5);
        rd_chk(vpwtmc_pkg::ADDR_STATUS, st(vpwtmc_pkg::MODE_SLEEP_WAIT, 1, 0, 0, 0), "status");
        wait_regen(1'b0);
        rd_chk(vpwtmc_pkg::ADDR_STATUS, st(vpwtmc_pkg::MODE_SLEEP, 0, 0, 0, 0), "status");
        pulse(10, 1'b0);
        `CHK("reg_enable_out", 1'b1, reg_enable_out);
        rd_chk(vpwtmc_pkg::ADDR_EVENT, 32'h1 << vpwtmc_pkg::EVT_BUS_WAKE, "event");
        wr(vpwtmc_pkg::ADDR_EVENT, 32'h00000001);
        go_sleep();
        @(posedge pclk) local_wake_input <= 1'b1;
        wait_regen(1'b1);
        rd_chk(vpwtmc_pkg::ADDR_EVENT, 32'h1 << vpwtmc_pkg::EVT_LOCAL_WAKE, "event");
        wr(vpwtmc_pkg::ADDR_EVENT, 32'h00000002);
        go_sleep();
        @(posedge pclk) local_wake_input <= 1'b0;
        wait_regen(1'b1);
        go_sleep();
        @(posedge pclk) standby_ctl_in <= 1'b1;
        wait_regen(1'b1);
        go_sleep();
        @(posedge pclk) supply_por_in <= 1'b1;
        settle(4);
        @(posedge pclk) supply_por_in <= 1'b0;
        wait_regen(1'b1);
        rd_chk(vpwtmc_pkg::ADDR_STATUS, st(vpwtmc_pkg::MODE_STANDBY, 1, 0, 0, 0), "status");
        $display("test sleep_wake done");
        tally_and_finish();
    end
endmodule : tb_vpw_transceiver_mode_control
`default_nettype wire
